// ### cmpu_top.sv
// Compare unit with time base select register on an Avalon-MM slave
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module cmpu_top #(
	parameter int CMP_W = 16
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic [CMP_W-1:0]  tmr_base_one,
	input  wire logic [CMP_W-1:0]  tmr_base_three,
	input  wire logic              pin_direction_bits,
	input  wire logic              port_latch,
	input  wire logic              eu2_trigger,
	input  wire logic              adc_enable,
	output logic                   compare_output_pin,
	output logic                   compare_output_pin_oe_n,
	output logic                   special_event,
	output logic [cmpu_pkg::PAIRS-1:0] tmr_pair_rst,
	output logic                   adc_start,
	output cmpu_pkg::cmpu_eu_tb_type eu_timebase,
	output logic [cmpu_pkg::PAIRS-1:0] eu1_pair_sel,
	output logic [cmpu_pkg::PAIRS-1:0] eu3_pair_sel,
	output logic                   irq
);
	// Refuse compare widths the read mux and bus cannot hold
	if (CMP_W < 2 || CMP_W > 32) begin : g_bad_width
		$error("CMP_W must be 2 to 32");
	end

	// Code to one-hot timer pair: 1/2,3/4,3/6,3/8,3/10,3/12; reserved codes pick none
	function automatic logic [cmpu_pkg::PAIRS-1:0] pair_onehot(input logic [2:0] code);
		logic [cmpu_pkg::PAIRS-1:0] sel;
		sel = '0;
		if (code < 3'(cmpu_pkg::PAIRS)) begin
			sel[code] = 1'b1;
		end
		return sel;
	endfunction : pair_onehot

	cmpu_pkg::cmpu_bus_req_type req;
	logic [3:0]                 compare_mode_field_r;
	logic [CMP_W-1:0]           compare_value_reg_r;
	logic [2:0]                 timebase_select_reg_a_r;
	cmpu_pkg::cmpu_eu_tb_type   eu_tb_r;
	logic [cmpu_pkg::IRQ_W-1:0] status_r;
	logic [cmpu_pkg::IRQ_W-1:0] mask_r;
	logic                       cmp_latch_r;
	logic                       cmp_latch_nxt;
	logic                       wait_r;
	logic [31:0]                rdata_r;
	logic [31:0]                rdata_nxt;
	logic                       pin_r;
	logic                       oe_n_r;
	logic                       sevt_r;
	logic [cmpu_pkg::PAIRS-1:0] pair_rst_r;
	logic                       adc_r;
	logic [cmpu_pkg::PAIRS-1:0] eu1_sel_r;
	logic [cmpu_pkg::PAIRS-1:0] eu3_sel_r;
	logic                       irq_r;

	// Bus request bundle and accept strobes
	logic wr_go;
	logic rd_go;
	logic sel_ctrl;
	logic sel_value;
	logic sel_tba;
	logic sel_eutb;
	logic sel_status;
	logic sel_mask;
	logic sel_state;
	assign req.address   = avs_address;
	assign req.read      = avs_read;
	assign req.write     = avs_write;
	assign req.writedata = avs_writedata;
	assign wr_go = req.write & ~wait_r;
	assign rd_go = req.read & wait_r;

	// Address decode
	assign sel_ctrl   = (req.address == cmpu_pkg::OFS_CTRL);
	assign sel_value  = (req.address == cmpu_pkg::OFS_VALUE);
	assign sel_tba    = (req.address == cmpu_pkg::OFS_TBSEL_A);
	assign sel_eutb   = (req.address == cmpu_pkg::OFS_EU_TB);
	assign sel_status = (req.address == cmpu_pkg::OFS_STATUS);
	assign sel_mask   = (req.address == cmpu_pkg::OFS_MASK);
	assign sel_state  = (req.address == cmpu_pkg::OFS_STATE);

	// Read mux, unmapped reads return zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (sel_ctrl) begin
			rdata_nxt[3:0] = compare_mode_field_r;
		end else if (sel_value) begin
			rdata_nxt[CMP_W-1:0] = compare_value_reg_r;
		end else if (sel_tba) begin
			rdata_nxt[2:0] = timebase_select_reg_a_r;
		end else if (sel_eutb) begin
			rdata_nxt[7:0] = eu_tb_r;
		end else if (sel_status) begin
			rdata_nxt[cmpu_pkg::IRQ_W-1:0] = status_r;
		end else if (sel_mask) begin
			rdata_nxt[cmpu_pkg::IRQ_W-1:0] = mask_r;
		end else if (sel_state) begin
			rdata_nxt[2:0] = {pin_r, oe_n_r, cmp_latch_r};
		end
	end

	// One wait cycle per access, data stands when waitrequest drops
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~((req.read | req.write) & wait_r);
			if (rd_go) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// Time base for this unit: CMP_W-bit timer of the chosen pair
	logic [CMP_W-1:0] base_count;
	logic             hit;
	logic             mode_cmp;
	logic             act;
	logic             ctrl_zero;
	assign base_count = (timebase_select_reg_a_r == 3'h0) ? tmr_base_one : tmr_base_three;

	cmpu_match #(
		.W (CMP_W)
	) u_match (
		.clk   (clk),
		.srst  (srst),
		.count (base_count),
		.value (compare_value_reg_r),
		.hit   (hit)
	);

	// Compare modes and the action of a match
	assign mode_cmp  = (compare_mode_field_r == cmpu_pkg::MODE_TOGGLE) ||
		(compare_mode_field_r[3:2] == 2'b10);
	assign act       = hit & mode_cmp;
	assign ctrl_zero = wr_go & sel_ctrl & (req.writedata[3:0] == 4'h0);

	// Next compare latch value
	always_comb begin
		cmp_latch_nxt = cmp_latch_r;
		if (ctrl_zero) begin
			cmp_latch_nxt = 1'b0;
		end else if (act) begin
			case (compare_mode_field_r)
				cmpu_pkg::MODE_HIGH:   cmp_latch_nxt = 1'b1;
				cmpu_pkg::MODE_LOW:    cmp_latch_nxt = 1'b0;
				cmpu_pkg::MODE_TOGGLE: cmp_latch_nxt = ~cmp_latch_r;
				default:               cmp_latch_nxt = cmp_latch_r;
			endcase
		end
	end

	// Pin drive: compare latch in pin modes, port latch otherwise
	logic pin_mode;
	assign pin_mode = (compare_mode_field_r == cmpu_pkg::MODE_TOGGLE) ||
		(compare_mode_field_r == cmpu_pkg::MODE_HIGH) ||
		(compare_mode_field_r == cmpu_pkg::MODE_LOW);

	// Control registers written by software
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_mode_field_r    <= cmpu_pkg::RST_MODE;
			compare_value_reg_r     <= '0;
			timebase_select_reg_a_r <= cmpu_pkg::RST_TBSEL;
			eu_tb_r                 <= cmpu_pkg::RST_EU_TB;
			mask_r                  <= '0;
		end else if (wr_go) begin
			if (sel_ctrl) begin
				compare_mode_field_r <= req.writedata[3:0];
			end
			if (sel_value) begin
				compare_value_reg_r <= req.writedata[CMP_W-1:0];
			end
			if (sel_tba) begin
				timebase_select_reg_a_r <= req.writedata[2:0];
			end
			if (sel_eutb) begin
				eu_tb_r <= req.writedata[7:0];
			end
			if (sel_mask) begin
				mask_r <= req.writedata[cmpu_pkg::IRQ_W-1:0];
			end
		end
	end

	// Sticky status, set wins over write-one-to-clear
	logic [cmpu_pkg::IRQ_W-1:0] st_set;
	logic [cmpu_pkg::IRQ_W-1:0] st_clr;
	logic                       sevt_go;
	assign sevt_go = act & (compare_mode_field_r == cmpu_pkg::MODE_SEVT);
	assign st_set  = {sevt_go, act};
	assign st_clr  = (wr_go & sel_status) ? req.writedata[cmpu_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (srst) begin
			status_r    <= '0;
			cmp_latch_r <= 1'b0;
		end else begin
			status_r    <= (status_r & ~st_clr) | st_set;
			cmp_latch_r <= cmp_latch_nxt;
		end
	end

	// Outputs, all registered
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_r      <= 1'b0;
			oe_n_r     <= 1'b1;
			sevt_r     <= 1'b0;
			pair_rst_r <= '0;
			adc_r      <= 1'b0;
			eu1_sel_r  <= '0;
			eu3_sel_r  <= '0;
			irq_r      <= 1'b0;
		end else begin
			pin_r      <= pin_mode ? cmp_latch_nxt : port_latch;
			oe_n_r     <= pin_direction_bits;
			sevt_r     <= sevt_go;
			pair_rst_r <= sevt_go ? pair_onehot(timebase_select_reg_a_r) : '0;
			adc_r      <= eu2_trigger & adc_enable;
			eu1_sel_r  <= pair_onehot(eu_tb_r.unit_one_timebase_field);
			eu3_sel_r  <= pair_onehot({1'b0, eu_tb_r.unit_three_timebase_field});
			irq_r      <= |(status_r & mask_r);
		end
	end

	assign avs_readdata            = rdata_r;
	assign avs_waitrequest         = wait_r;
	assign compare_output_pin      = pin_r;
	assign compare_output_pin_oe_n = oe_n_r;
	assign special_event           = sevt_r;
	assign tmr_pair_rst            = pair_rst_r;
	assign adc_start               = adc_r;
	assign eu_timebase             = eu_tb_r;
	assign eu1_pair_sel            = eu1_sel_r;
	assign eu3_pair_sel            = eu3_sel_r;
	assign irq                     = irq_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_match_mode(logic [3:0] m);
		act && compare_mode_field_r == m && !ctrl_zero;
	endsequence

	a_drive_high: assert property (s_match_mode(cmpu_pkg::MODE_HIGH) |=> cmp_latch_r)
		else $error("High mode match did not set latch");
	a_drive_low: assert property (s_match_mode(cmpu_pkg::MODE_LOW) |=> !cmp_latch_r)
		else $error("Low mode match did not clear latch");
	a_toggle_pin: assert property (s_match_mode(cmpu_pkg::MODE_TOGGLE)
		|=> cmp_latch_r != $past(cmp_latch_r))
		else $error("Toggle mode match did not toggle latch");
	a_flag_set: assert property (act |=> status_r[cmpu_pkg::IRQ_CMP])
		else $error("Match did not set compare flag");
	a_ctrl_zero: assert property (ctrl_zero |=> !cmp_latch_r ##1
		(compare_output_pin == $past(port_latch)))
		else $error("Zero control write did not clear latch");
	a_swint_pin: assert property (s_match_mode(cmpu_pkg::MODE_SWINT)
		|=> $stable(cmp_latch_r) && status_r[cmpu_pkg::IRQ_CMP])
		else $error("Software interrupt mode moved the latch");
	a_sevt_reset: assert property (sevt_go |=> special_event &&
		tmr_pair_rst == pair_onehot($past(timebase_select_reg_a_r)))
		else $error("Special event did not reset the time base pair");
	a_adc_gate: assert property (adc_start |-> $past(eu2_trigger) && $past(adc_enable))
		else $error("Conversion started without enabled converter");
	a_irq_level: assert property (status_r[0] && mask_r[0] |=> irq)
		else $error("Enabled compare flag did not raise interrupt");
endmodule : cmpu_top

// ### cmpu_pkg.sv
// Constants, field layouts and carrier types for the compare unit and timer select
//Behaviour
//- Compare value is checked every cycle against the chosen time base count.
//- On match the pin goes high, low, toggles or stays, per mode field.
//- The compare interrupt flag is set in the same cycle the match acts.
//- Writing zero to the control register forces the compare latch low.
//- Mode 1010 leaves the pin alone and only raises the interrupt.
//- Mode 1011 makes a match emit a special event trigger pulse.
//- The special event trigger resets the time base timer pair.
//- This unit's special event trigger never starts a conversion.
//- Unit two's trigger starts a conversion only while the converter is enabled.
//- Unit one three-bit field picks 1/2, 3/4, 3/6, 3/8, 3/10, 3/12.
package cmpu_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_VALUE   = 5'h04;
	localparam logic [4:0] OFS_TBSEL_A = 5'h08;
	localparam logic [4:0] OFS_EU_TB   = 5'h0C;
	localparam logic [4:0] OFS_STATUS  = 5'h10;
	localparam logic [4:0] OFS_MASK    = 5'h14;
	localparam logic [4:0] OFS_STATE   = 5'h18;
	// Reset values
	localparam logic [3:0] RST_MODE    = 4'h0;
	localparam logic [7:0] RST_EU_TB   = 8'h00;
	localparam logic [2:0] RST_TBSEL   = 3'h0;
	// Compare modes
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_HIGH   = 4'h8;
	localparam logic [3:0] MODE_LOW    = 4'h9;
	localparam logic [3:0] MODE_SWINT  = 4'hA;
	localparam logic [3:0] MODE_SEVT   = 4'hB;
	// Status and mask bit positions
	localparam int IRQ_CMP  = 0;
	localparam int IRQ_SEVT = 1;
	localparam int IRQ_W    = 2;
	localparam int PAIRS    = 6;

	typedef struct packed {
		logic [1:0] unit_three_timebase_field;
		logic [2:0] unit_two_timebase_field;
		logic [2:0] unit_one_timebase_field;
	} cmpu_eu_tb_type;

	typedef struct packed {
		logic [4:0] address;
		logic       read;
		logic       write;
		logic [31:0] writedata;
	} cmpu_bus_req_type;
endpackage : cmpu_pkg

// ### cmpu_match.sv
// One-shot equality detector between compare value and time base count
`timescale 1ns/100ps
module cmpu_match #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] count,
	input  wire logic [W-1:0] value,
	output logic              hit
);
	logic eq;
	logic eq_prev_r;

	// Equality checked continuously
	assign eq  = (count == value);
	assign hit = eq & ~eq_prev_r;

	// Remember last equality so a held match fires once
	always_ff @(posedge clk) begin
		if (srst) begin
			eq_prev_r <= 1'b0;
		end else begin
			eq_prev_r <= eq;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_match_once: assert property (hit |=> !hit)
		else $error("Match fired on two cycles in a row");
	a_match_cause: assert property ((count == value) && !$past(count == value) |-> hit)
		else $error("First equality did not produce a match");
endmodule : cmpu_match

// ### cmpu_pin_load.sv
// Load model hanging on the compare output pin
`timescale 1ns/100ps
module cmpu_pin_load (
	input  wire logic pin,
	input  wire logic oe_n,
	output logic      level
);
	// Weak pull-up holds the line while the pin is released
	assign level = oe_n ? 1'b1 : pin;
endmodule : cmpu_pin_load

// ### cmpu_top_bench.sv
// Self-checking bench for the compare unit and time base select
`timescale 1ns/100ps
module cmpu_top_bench;
	logic                     clk, srst, avs_read, avs_write, avs_waitrequest;
	logic                     pin_direction_bits, port_latch, eu2_trigger, adc_enable;
	logic                     compare_output_pin, compare_output_pin_oe_n, special_event;
	logic                     adc_start, irq, level;
	logic [4:0]               avs_address;
	logic [31:0]              avs_writedata, avs_readdata, rdv, s0, a0;
	logic [31:0]              bad_count, num_checks, cyc, sevt_n, adc_n;
	logic [15:0]              tmr_one, tmr_three;
	logic [5:0]               tmr_pair_rst, rst_last, eu1_pair_sel, eu3_pair_sel;
	cmpu_pkg::cmpu_eu_tb_type eu_timebase;
	int                       i;

	cmpu_top cmpu_top_i (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.tmr_base_one(tmr_one), .tmr_base_three(tmr_three),
		.pin_direction_bits(pin_direction_bits), .port_latch(port_latch),
		.eu2_trigger(eu2_trigger), .adc_enable(adc_enable),
		.compare_output_pin(compare_output_pin),
		.compare_output_pin_oe_n(compare_output_pin_oe_n), .special_event(special_event),
		.tmr_pair_rst(tmr_pair_rst), .adc_start(adc_start), .eu_timebase(eu_timebase),
		.eu1_pair_sel(eu1_pair_sel), .eu3_pair_sel(eu3_pair_sel), .irq(irq));
	cmpu_pin_load cmpu_pin_load_i (.pin(compare_output_pin),
		.oe_n(compare_output_pin_oe_n), .level(level));

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulse counters and cycle count
	always @(posedge clk) begin
		cyc <= cyc + 32'h0000_0001;
		if (special_event === 1'b1) sevt_n <= sevt_n + 32'h0000_0001;
		if (adc_start === 1'b1) adc_n <= adc_n + 32'h0000_0001;
		if (tmr_pair_rst !== 6'h00) rst_last <= tmr_pair_rst;
		if (cyc == 32'h0000_0FA0) begin
			bad_count = bad_count + 32'h0000_0001;
			results();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 32'h0000_0001;
		if (seen !== exp) begin
			bad_count = bad_count + 32'h0000_0001;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge clk iff (avs_waitrequest === 1'b0));
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [4:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk iff (avs_waitrequest === 1'b0));
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : rd

	// Arms a mode and value, then brings the chosen timer onto the value
	task hit(input logic [3:0] m, input logic [15:0] v, input logic t3);
		tmr_one <= 16'h0000;
		tmr_three <= 16'h0000;
		wr(cmpu_pkg::OFS_VALUE, {16'h0000, v});
		wr(cmpu_pkg::OFS_CTRL, {28'h000_0000, m});
		if (t3) tmr_three <= v;
		else tmr_one <= v;
		repeat (4) @(posedge clk);
	endtask : hit

	task results;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 32'h0000_0000 && num_checks > 32'h0000_0000) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Main sequence
	initial begin
		{srst, avs_read, avs_write, port_latch, eu2_trigger, adc_enable} = 6'h20;
		{avs_address, avs_writedata, tmr_one, tmr_three} = '0;
		{bad_count, num_checks, cyc, sevt_n, adc_n, rst_last} = '0;
		pin_direction_bits = 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk(compare_output_pin_oe_n, 32'h0000_0001);
		chk(irq, 32'h0000_0000);
		for (i = 0; i < 8; i++) begin
			rd(5'(i * 4), rdv);
			chk(rdv, (i == 6) ? 32'h0000_0002 : 32'h0000_0000);
		end
		wr(5'h1C, 32'hFFFF_FFFF);
		rd(5'h1C, rdv);
		chk(rdv, 32'h0000_0000);
		// Every legal select code; unit two stays at 000
		for (i = 0; i < 6; i++) begin
			wr(cmpu_pkg::OFS_EU_TB, {24'h00_0000, 2'(i), 3'h0, 3'(i)});
			@(posedge clk);
			chk(eu_timebase, {24'h00_0000, 2'(i), 3'h0, 3'(i)});
			chk(eu1_pair_sel, 6'h01 << i);
			chk(eu3_pair_sel, 6'h01 << i[1:0]);
		end
		pin_direction_bits <= 1'b0;
		port_latch <= 1'b1;
		hit(cmpu_pkg::MODE_HIGH, 16'h1234, 1'b0);
		chk(level, 32'h0000_0001);
		chk(irq, 32'h0000_0000);
		rd(cmpu_pkg::OFS_STATUS, rdv);
		chk(rdv, 32'h0000_0001);
		wr(cmpu_pkg::OFS_STATUS, 32'h0000_0001);
		repeat (3) @(posedge clk);
		rd(cmpu_pkg::OFS_STATUS, rdv);
		chk(rdv, 32'h0000_0000);
		hit(cmpu_pkg::MODE_LOW, 16'h0001, 1'b0);
		chk(compare_output_pin, 32'h0000_0000);
		hit(cmpu_pkg::MODE_TOGGLE, 16'hFFFF, 1'b0);
		chk(compare_output_pin, 32'h0000_0001);
		hit(cmpu_pkg::MODE_TOGGLE, 16'h8000, 1'b0);
		chk(compare_output_pin, 32'h0000_0000);
		hit(cmpu_pkg::MODE_HIGH, 16'h0042, 1'b0);
		wr(cmpu_pkg::OFS_CTRL, 32'h0000_0000);
		rd(cmpu_pkg::OFS_STATE, rdv);
		chk(rdv, 32'h0000_0004);
		// Software interrupt, enabled then masked
		port_latch <= 1'b0;
		wr(cmpu_pkg::OFS_STATUS, 32'h0000_0003);
		wr(cmpu_pkg::OFS_MASK, 32'h0000_0001);
		hit(cmpu_pkg::MODE_SWINT, 16'h0777, 1'b0);
		chk(compare_output_pin, 32'h0000_0000);
		chk(irq, 32'h0000_0001);
		rd(cmpu_pkg::OFS_STATE, rdv);
		chk(rdv, 32'h0000_0000);
		wr(cmpu_pkg::OFS_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0000_0000);
		wr(cmpu_pkg::OFS_MASK, 32'h0000_0000);
		hit(cmpu_pkg::MODE_SWINT, 16'h0700, 1'b0);
		chk(irq, 32'h0000_0000);
		// Special event on the 3/8 pair
		wr(cmpu_pkg::OFS_STATUS, 32'h0000_0003);
		wr(cmpu_pkg::OFS_TBSEL_A, 32'h0000_0003);
		s0 = sevt_n;
		a0 = adc_n;
		hit(cmpu_pkg::MODE_SEVT, 16'h0100, 1'b1);
		chk(sevt_n - s0, 32'h0000_0001);
		chk(rst_last, 32'h0000_0008);
		chk(adc_n - a0, 32'h0000_0000);
		rd(cmpu_pkg::OFS_STATUS, rdv);
		chk(rdv, 32'h0000_0003);
		// Unit two trigger, converter off then on
		for (i = 0; i < 2; i++) begin
			adc_enable <= 1'(i);
			eu2_trigger <= 1'b1;
			@(posedge clk);
			eu2_trigger <= 1'b0;
			repeat (3) @(posedge clk);
			chk(adc_n - a0, 32'(i));
		end
		results();
	end
endmodule : cmpu_top_bench
